// ### rtl/emb_pkg.sv
package emb_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 3;
    localparam int SYNC_STAGES = 3;

    // ****************************************************************
    // space encodings on the request port
    // ****************************************************************
    localparam logic [1:0] SPACE_DATA = 2'h0;
    localparam logic [1:0] SPACE_PROG = 2'h1;
    localparam logic [1:0] SPACE_IO = 2'h2;

    // ****************************************************************
    // counts and reset values
    // ****************************************************************
    localparam logic [WAIT_W-1:0] READY_MIN_WAITS = 3'h2;
    // cycles a pin level needs to clear the three-stage synchroniser
    localparam logic [WAIT_W-1:0] READY_SETTLE = 3'h4;
    localparam logic [WAIT_W-1:0] WAIT_RST = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic PIN_IDLE_N = 1'h1;
    localparam logic SYNC_RST = 1'h1;

    typedef enum logic [1:0] {
        EMB_IDLE,
        EMB_ACCESS,
        EMB_HOLD
    } emb_state_t;

endpackage

// ### rtl/emb_sync3.sv
`timescale 1ns/10ps
module emb_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic async_in,
    output logic level_out
);
    import emb_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ****************************************************************
    // three stages; level moves once stages two and three agree
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
            level_out <= SYNC_RST;
        end else if (ce) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_out <= s3_reg;
            end
        end
    end

endmodule

// ### rtl/emb_wait_seq.sv
`timescale 1ns/10ps
module emb_wait_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [emb_pkg::WAIT_W-1:0] load_waits,
    output logic waits_done,
    output logic ready_check,
    output logic wait_flag_n
);
    import emb_pkg::*;

    logic [WAIT_W-1:0] count_reg;
    logic [WAIT_W-1:0] total_reg;

    assign waits_done = (count_reg == WAIT_RST);

    // ****************************************************************
    // software wait state counter
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= WAIT_RST;
            total_reg <= WAIT_RST;
            ready_check <= 1'h0;
        end else if (ce) begin
            if (load) begin
                count_reg <= load_waits;
                total_reg <= load_waits;
                ready_check <= (load_waits >= READY_MIN_WAITS);
            end else if (!waits_done) begin
                count_reg <= count_reg - 3'h1;
            end
        end
    end

    // ****************************************************************
    // microstate flag: low at first wait, high at last wait, only with two or more waits
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_flag_n <= PIN_IDLE_N;
        end else if (ce && !load && !waits_done &&
                     total_reg >= READY_MIN_WAITS) begin
            if (count_reg == total_reg) begin
                wait_flag_n <= 1'h0;
            end else if (count_reg == 3'h1) begin
                wait_flag_n <= 1'h1;
            end
        end
    end

endmodule

// ### rtl/emb_bus_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - memory strobe idles high, low during any access whose space is not I/O
// - I/O strobe idles high, low only during I/O accesses
// - direction output reads high, low only during an external write
// - hold mode floats memory strobe, I/O strobe and direction
// - float input low puts all control outputs into high impedance
// - ready low stalls one more cycle then samples again
// - ready is only checked with two or more software waits
// - ready is not sampled before software waits have elapsed
// - granted hold floats address, data, control and asserts acknowledge
// - wait-done goes low at first wait, high at last, only with two or more software waits
// - wait-done looped into ready adds one external wait with three or more software waits
// - fetch flag is low while a fetch address is on the bus
// - space selects idle high, one low while its address is valid
module emb_bus_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_space,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [emb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [emb_pkg::DATA_W-1:0] req_wdata,
    input wire logic [emb_pkg::WAIT_W-1:0] req_waits,
    output logic done,
    output logic [emb_pkg::DATA_W-1:0] rdata,
    output logic [emb_pkg::ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [emb_pkg::DATA_W-1:0] data_out,
    input wire logic [emb_pkg::DATA_W-1:0] data_in,
    output logic data_oe,
    output logic memory_strobe_n,
    output logic memory_strobe_oe,
    output logic io_strobe_n,
    output logic io_strobe_oe,
    output logic xfer_read,
    output logic xfer_read_oe,
    output logic data_space_select_n,
    output logic program_space_select_n,
    output logic io_space_select_n,
    output logic space_select_oe,
    output logic bus_release_ack_n,
    output logic bus_release_ack_oe,
    output logic wait_states_done_n,
    output logic wait_states_done_oe,
    output logic instr_fetch_flag_n,
    output logic instr_fetch_flag_oe,
    input wire logic hold_req_n,
    input wire logic float_n,
    input wire logic ready
);
    import emb_pkg::*;

    emb_state_t state_reg;
    emb_state_t state_next;
    logic hold_sync;
    logic float_sync;
    logic ready_sync;
    logic waits_done;
    logic ready_check;
    logic wait_flag_n;
    logic start;
    logic finish;
    logic bus_oe_reg;
    logic pin_oe_reg;
    logic write_reg;
    logic [WAIT_W-1:0] settle_reg;

    // ****************************************************************
    // pin synchronisers and wait state counter
    // ****************************************************************
    emb_sync3 u_sync_hold (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .async_in(hold_req_n),
        .level_out(hold_sync)
    );

    emb_sync3 u_sync_float (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .async_in(float_n),
        .level_out(float_sync)
    );

    emb_sync3 u_sync_ready (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .async_in(ready),
        .level_out(ready_sync)
    );

    emb_wait_seq u_wait (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(start),
        .load_waits(req_waits),
        .waits_done(waits_done),
        .ready_check(ready_check),
        .wait_flag_n(wait_flag_n)
    );

    // ****************************************************************
    // access sequencing
    // ****************************************************************
    assign start = (state_reg == EMB_IDLE) && hold_sync && req_valid;
    // ready is trusted only once the synchroniser shows it after the waits
    assign finish = (state_reg == EMB_ACCESS) && waits_done &&
                    (!ready_check || (ready_sync &&
                     settle_reg == READY_SETTLE));

    always_ff @(posedge clk) begin
        if (rst || (ce && start)) begin
            settle_reg <= WAIT_RST;
        end else if (ce && (state_reg == EMB_ACCESS) && waits_done &&
                     settle_reg != READY_SETTLE) begin
            settle_reg <= settle_reg + 3'h1;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            EMB_IDLE: begin
                if (!hold_sync) begin
                    state_next = EMB_HOLD;
                end else if (req_valid) begin
                    state_next = EMB_ACCESS;
                end
            end
            EMB_ACCESS: begin
                if (finish) begin
                    state_next = EMB_IDLE;
                end
            end
            EMB_HOLD: begin
                if (hold_sync) begin
                    state_next = EMB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= EMB_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req_ready <= 1'h0;
        end else if (ce) begin
            req_ready <= (state_next == EMB_IDLE) && hold_sync;
        end
    end

    // ****************************************************************
    // strobes, direction, selects and fetch flag
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            memory_strobe_n <= PIN_IDLE_N;
            io_strobe_n <= PIN_IDLE_N;
            xfer_read <= PIN_IDLE_N;
            write_reg <= 1'h0;
            data_space_select_n <= PIN_IDLE_N;
            program_space_select_n <= PIN_IDLE_N;
            io_space_select_n <= PIN_IDLE_N;
            instr_fetch_flag_n <= PIN_IDLE_N;
        end else if (ce) begin
            if (start) begin
                memory_strobe_n <= (req_space == SPACE_IO);
                io_strobe_n <= (req_space != SPACE_IO);
                xfer_read <= !req_write;
                write_reg <= req_write;
                data_space_select_n <= (req_space != SPACE_DATA);
                program_space_select_n <= (req_space != SPACE_PROG);
                io_space_select_n <= (req_space != SPACE_IO);
                instr_fetch_flag_n <= !(req_fetch &&
                                        req_space == SPACE_PROG);
            end else if (finish) begin
                memory_strobe_n <= PIN_IDLE_N;
                io_strobe_n <= PIN_IDLE_N;
                xfer_read <= PIN_IDLE_N;
                write_reg <= 1'h0;
                data_space_select_n <= PIN_IDLE_N;
                program_space_select_n <= PIN_IDLE_N;
                io_space_select_n <= PIN_IDLE_N;
                instr_fetch_flag_n <= PIN_IDLE_N;
            end
        end
    end

    // ****************************************************************
    // address, data and completion
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_out <= ADDR_RST;
            data_out <= DATA_RST;
            rdata <= DATA_RST;
            done <= 1'h0;
        end else if (ce) begin
            done <= finish;
            if (start) begin
                addr_out <= req_addr;
                data_out <= req_wdata;
            end
            // data is qualified by the strobe, so no synchroniser
            if (finish && !write_reg) begin
                rdata <= data_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_states_done_n <= PIN_IDLE_N;
        end else if (ce) begin
            wait_states_done_n <= wait_flag_n;
        end
    end

    // ****************************************************************
    // hold handshake and output enables
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_release_ack_n <= PIN_IDLE_N;
        end else if (ce) begin
            bus_release_ack_n <= (state_next != EMB_HOLD);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_oe_reg <= 1'h0;
            pin_oe_reg <= 1'h0;
            data_oe <= 1'h0;
        end else if (ce) begin
            bus_oe_reg <= float_sync && (state_next != EMB_HOLD);
            pin_oe_reg <= float_sync;
            data_oe <= float_sync && (state_next == EMB_ACCESS) &&
                       (start ? req_write : write_reg);
        end
    end

    assign addr_oe = bus_oe_reg;
    assign memory_strobe_oe = bus_oe_reg;
    assign io_strobe_oe = bus_oe_reg;
    assign xfer_read_oe = bus_oe_reg;
    assign space_select_oe = bus_oe_reg;
    assign bus_release_ack_oe = pin_oe_reg;
    assign wait_states_done_oe = pin_oe_reg;
    assign instr_fetch_flag_oe = pin_oe_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_access_start;
        ce && start;
    endsequence

    sequence s_access_end;
        ce && finish;
    endsequence

    a_mem_strobe_idle: assert property (
        (state_reg != EMB_ACCESS) |-> memory_strobe_n)
        else $error("memory strobe low outside an access");

    a_io_strobe_space: assert property (
        s_access_start ##1 1'b1 |-> (io_strobe_n == (req_space != SPACE_IO)))
        else $error("io strobe does not follow space");

    a_dir_read_idle: assert property (
        !xfer_read |-> (state_reg == EMB_ACCESS) && write_reg)
        else $error("direction low without a write");

    a_hold_float: assert property (
        (state_reg == EMB_HOLD) |-> !memory_strobe_oe && !xfer_read_oe)
        else $error("control driven in hold");

    a_float_all: assert property (
        ce && !float_sync |=> !pin_oe_reg && !bus_oe_reg)
        else $error("outputs driven while floated");

    a_ready_stall: assert property (
        (state_reg == EMB_ACCESS) && waits_done && ready_check &&
        !ready_sync && ce |=> (state_reg == EMB_ACCESS) && !done)
        else $error("ready low did not stall");

    a_no_ready_check: assert property (
        (state_reg == EMB_ACCESS) && waits_done && !ready_check && ce
        |=> done)
        else $error("access stalled without ready check");

    a_waits_first: assert property (
        s_access_start ##1 (!waits_done) |-> !finish)
        else $error("access ended before software waits");

    a_hold_ack: assert property (
        ce && (state_reg == EMB_IDLE) && !hold_sync
        |=> !bus_release_ack_n && !addr_oe && !data_oe)
        else $error("hold not granted");

    a_wait_flag_window: assert property (
        s_access_start ##1 (ready_check && ce) |=> !wait_flag_n)
        else $error("wait-done not low at first wait");

    a_fetch_flag: assert property (
        !instr_fetch_flag_n |-> !program_space_select_n)
        else $error("fetch flag without program address");

    a_select_one: assert property (
        s_access_end |=> data_space_select_n && program_space_select_n &&
        io_space_select_n)
        else $error("select left low after access");

endmodule

// ### test/emb_mem_model.sv
`timescale 1ns/10ps
module emb_mem_model (
    input wire logic clk,
    input wire logic strobe_n,
    input wire logic xfer_read,
    input wire logic [emb_pkg::ADDR_W-1:0] addr_out,
    input wire logic [emb_pkg::DATA_W-1:0] data_out,
    input wire logic wait_done_n,
    input wire logic loop_done,
    input wire logic [3:0] stall,
    output logic [emb_pkg::DATA_W-1:0] data_in,
    output logic ready
);
    import emb_pkg::*;
    logic [DATA_W-1:0] mem_reg [16];
    logic [DATA_W-1:0] last_reg = DATA_RST;
    logic [3:0] cnt_reg = 4'h0;
    // ****************************************************************
    // storage, read data and released bus
    // ****************************************************************
    always @(posedge clk) begin
        if (!strobe_n && !xfer_read) begin
            mem_reg[addr_out[3:0]] <= data_out;
        end
        if (!strobe_n && xfer_read) begin
            last_reg <= data_in;
        end
    end
    // released bus shows the inverse of the last word, never a stale copy
    always_comb begin
        if (!strobe_n && xfer_read) begin
            data_in = mem_reg[addr_out[3:0]];
        end else begin
            data_in = ~last_reg;
        end
    end
    // ****************************************************************
    // ready: low for stall cycles of each access, or looped wait-done
    // ****************************************************************
    always @(posedge clk) begin
        if (strobe_n) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hF) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    assign ready = loop_done ? wait_done_n :
                   (strobe_n || cnt_reg >= stall);
endmodule

// ### test/test_external_memory_bus_control.sv
`timescale 1ns/10ps
module test_external_memory_bus_control;
    import emb_pkg::*;
    logic clk, rst, ce, req_valid, req_ready, req_write, req_fetch, done;
    logic [1:0] req_space;
    logic [ADDR_W-1:0] req_addr, addr_out;
    logic [DATA_W-1:0] req_wdata, rdata, data_out, data_in;
    logic [WAIT_W-1:0] req_waits;
    logic addr_oe, data_oe, memory_strobe_n, memory_strobe_oe, io_strobe_n;
    logic io_strobe_oe, xfer_read, xfer_read_oe, data_space_select_n;
    logic program_space_select_n, io_space_select_n, space_select_oe;
    logic bus_release_ack_n, bus_release_ack_oe, wait_states_done_n;
    logic wait_states_done_oe, instr_fetch_flag_n, instr_fetch_flag_oe;
    logic hold_req_n, float_n, ready, loop_done;
    logic [3:0] stall;
    logic [7:0] low_pins, seen;
    int n_errors, n_checks, lat;
    emb_bus_ctrl i_dut (.clk, .rst, .ce, .req_valid, .req_ready, .req_space,
        .req_write, .req_fetch, .req_addr, .req_wdata, .req_waits, .done,
        .rdata, .addr_out, .addr_oe, .data_out, .data_in, .data_oe,
        .memory_strobe_n, .memory_strobe_oe, .io_strobe_n, .io_strobe_oe,
        .xfer_read, .xfer_read_oe, .data_space_select_n,
        .program_space_select_n, .io_space_select_n, .space_select_oe,
        .bus_release_ack_n, .bus_release_ack_oe, .wait_states_done_n,
        .wait_states_done_oe, .instr_fetch_flag_n, .instr_fetch_flag_oe,
        .hold_req_n, .float_n, .ready);
    emb_mem_model i_mem (.clk, .strobe_n(memory_strobe_n & io_strobe_n),
        .xfer_read, .addr_out, .data_out, .wait_done_n(wait_states_done_n),
        .loop_done, .stall, .data_in, .ready);
    // active pins: mem, io, write, data, prog, io space, fetch, wait-done
    assign low_pins = ~{memory_strobe_n, io_strobe_n, xfer_read,
        data_space_select_n, program_space_select_n, io_space_select_n,
        instr_fetch_flag_n, wait_states_done_n};
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic expire(input int k);
        if (k >= 40) begin
            n_errors++;
            $display("wrong value wait: expected end, seen timeout");
            print_verdict();
        end
    endtask
    task automatic access(input logic [1:0] sp, input logic wr, fe,
            input logic [15:0] a, d, input logic [2:0] w);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1 k++;
        end
        expire(k);
        @(posedge clk);
        req_valid <= 1'b1;
        req_space <= sp;
        req_write <= wr;
        req_fetch <= fe;
        req_addr <= a;
        req_wdata <= d;
        req_waits <= w;
        @(posedge clk);
        req_valid <= 1'b0;
        lat = 0;
        seen = 8'h00;
        repeat (40) begin
            #1;
            if (done === 1'b1) break;
            seen |= low_pins;
            lat++;
            @(posedge clk);
        end
        expire(lat);
        check("idle pins", 16'h0000, 16'(low_pins));
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_data;
        access(SPACE_DATA, 1'b1, 1'b0, 16'h0005, 16'hA55A, 3'h0);
        check("write latency", 16'h0001, 16'(lat));
        check("write pins", 16'h00B0, 16'(seen));
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0005, 16'h0000, 3'h0);
        check("read pins", 16'h0090, 16'(seen));
        check("read data", 16'hA55A, rdata);
        $display("data space test done");
    endtask
    task automatic t_io_fetch;
        access(SPACE_IO, 1'b1, 1'b0, 16'h0002, 16'h1234, 3'h0);
        check("io pins", 16'h0064, 16'(seen));
        access(SPACE_PROG, 1'b0, 1'b1, 16'h0009, 16'h0000, 3'h0);
        check("fetch pins", 16'h008A, 16'(seen));
        $display("io and fetch test done");
    endtask
    task automatic t_waits;
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0001, 16'h0000, 3'h3);
        check("three waits", 16'h0008, 16'(lat));
        check("wait-done pins", 16'h0091, 16'(seen));
        stall = 4'hF;
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0001, 16'h0000, 3'h1);
        check("one wait", 16'h0002, 16'(lat));
        check("one wait pins", 16'h0090, 16'(seen));
        stall = 4'h2;
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0001, 16'h0000, 3'h7);
        check("early ready low", 16'h000C, 16'(lat));
        $display("wait state test done");
    endtask
    task automatic t_stall;
        stall = 4'h6;
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0003, 16'h0000, 3'h2);
        check("stalled", 16'h0001, 16'(lat > 6 && lat < 16));
        stall = 4'h0;
        loop_done = 1'b1;
        // one cycle more than the plain three-wait access
        access(SPACE_DATA, 1'b0, 1'b0, 16'h0003, 16'h0000, 3'h3);
        check("looped", 16'h0009, 16'(lat));
        loop_done = 1'b0;
        $display("ready stall test done");
    endtask
    task automatic t_hold;
        int k;
        @(posedge clk);
        hold_req_n <= 1'b0;
        k = 0;
        while (bus_release_ack_n !== 1'b0 && k < 40) begin
            @(posedge clk);
            #1 k++;
        end
        expire(k);
        check("hold oe", 16'h0000, 16'({addr_oe, data_oe, memory_strobe_oe,
            io_strobe_oe, xfer_read_oe, space_select_oe}));
        check("ready in hold", 16'h0000, 16'(req_ready));
        @(posedge clk);
        hold_req_n <= 1'b1;
        k = 0;
        while (bus_release_ack_n !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1 k++;
        end
        expire(k);
        check("oe after hold", 16'h0007, 16'({memory_strobe_oe,
            io_strobe_oe, xfer_read_oe}));
        $display("hold test done");
    endtask
    task automatic t_float;
        int k;
        @(posedge clk);
        float_n <= 1'b0;
        k = 0;
        while (wait_states_done_oe !== 1'b0 && k < 40) begin
            @(posedge clk);
            #1 k++;
        end
        expire(k);
        check("float oe", 16'h0000, 16'({memory_strobe_oe, io_strobe_oe,
            xfer_read_oe, bus_release_ack_oe, instr_fetch_flag_oe,
            space_select_oe}));
        @(posedge clk);
        float_n <= 1'b1;
        $display("float test done");
    endtask
    // ****************************************************************
    // clock, reset and sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, ce, hold_req_n, float_n} = 4'hF;
        {req_valid, req_write, req_fetch, loop_done} = 4'h0;
        req_space = SPACE_DATA;
        req_addr = ADDR_RST;
        req_wdata = DATA_RST;
        req_waits = WAIT_RST;
        stall = 4'h0;
        n_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_data();
        t_io_fetch();
        t_waits();
        t_stall();
        t_hold();
        t_float();
        print_verdict();
    end
endmodule
